// [inc/ald_pkg.sv]
`default_nettype none

package ald_pkg;

    // ==========================================================
    // Operation codes
    typedef enum logic [4:0] {
        ALD_ADD      = 5'h00,
        ALD_ADDC     = 5'h01,
        ALD_SUB      = 5'h02,
        ALD_SUBC     = 5'h03,
        ALD_MUL      = 5'h04,
        ALD_DIV      = 5'h05,
        ALD_DIVL     = 5'h06,
        ALD_ONES     = 5'h07,
        ALD_TWOS     = 5'h08,
        ALD_AND      = 5'h09,
        ALD_OR       = 5'h0A,
        ALD_XOR      = 5'h0B,
        ALD_BIT_COPY = 5'h0C,
        ALD_BIT_AND  = 5'h0D,
        ALD_BIT_OR   = 5'h0E,
        ALD_BIT_XOR  = 5'h0F,
        ALD_BIT_CMP  = 5'h10,
        ALD_FIELD    = 5'h11,
        ALD_CMP      = 5'h12,
        ALD_CMP_DEC  = 5'h13,
        ALD_CMP_INC  = 5'h14,
        ALD_NORM     = 5'h15,
        ALD_SHL      = 5'h16,
        ALD_SHR      = 5'h17,
        ALD_ROL      = 5'h18,
        ALD_ROR      = 5'h19,
        ALD_SIGN_FILL_RIGHT_SHIFT     = 5'h1A
    } ald_op_e;

    // ==========================================================
    // Widths and reset values
    localparam int          ALD_WORD_W   = 16;
    localparam int          ALD_BYTE_W   = 8;
    localparam logic [15:0] ALD_WORD_RST = 16'h0000;
    localparam logic [3:0]  ALD_FLAG_RST = 4'h0;
    localparam logic [15:0] ALD_STEP_ONE = 16'h0001;
    localparam logic [15:0] ALD_STEP_TWO = 16'h0002;

    typedef struct packed {
        logic z;
        logic n;
        logic c;
        logic v;
    } ald_flags_s;

    typedef struct packed {
        logic        valid;
        ald_op_e     op;
        logic        byte_mode;
        logic        signed_mode;
        logic        variant;
        logic [15:0] opa;
        logic [15:0] opb;
        logic [31:0] pair;
        logic        carry_in;
        logic        bit_dst;
        logic        bit_src;
        logic [7:0]  mask;
        logic [7:0]  imm;
    } ald_req_s;

    typedef struct packed {
        logic        valid;
        logic        write_dst;
        logic        write_pair;
        logic [15:0] result;
        logic [15:0] result_hi;
        ald_flags_s  flags;
    } ald_rsp_s;

endpackage

`default_nettype wire

// [rtl/ald_datapath.sv]
// Summary of operation
// RULE1: Add word or byte, optionally with carry
// RULE2: Subtract word or byte, optionally with borrow
// RULE3: Signed or unsigned 16 by 16 multiply
// RULE4: Divide low result word by register
// RULE5: Divide 32-bit pair by 16-bit register
// RULE6: Ones complement of word or byte
// RULE7: Twos complement negate of word or byte
// RULE8: Bitwise AND, OR, XOR on operands
// RULE9: Copy bit, optionally inverted
// RULE10: Combine two bits by AND, OR, XOR
// RULE11: Compare two bits, change neither
// RULE12: Masked insert into high or low byte
// RULE13: Compare operands, flags only
// RULE14: Compare then decrement by one or two
// RULE15: Compare then increment by one or two
// RULE16: Count shifts needed to normalize word
// RULE17: Logical shift left or right
// RULE18: Rotate left or right
// RULE19: Arithmetic right shift with sign fill
// RULE20: Update zero, negative, carry, overflow flags
`timescale 1ns/100ps
`default_nettype none

module ald_datapath (
    input  wire logic              i_clock,
    input  wire logic              i_rst,
    input  wire ald_pkg::ald_req_s i_req,
    output var  ald_pkg::ald_rsp_s o_rsp
);
    import ald_pkg::*;

    // ==========================================================
    // Operation decode
    logic [16:0] sum_w;
    logic [8:0]  sum_b;
    logic        add_cin;
    logic [15:0] add_b;
    logic        is_sub;
    logic [3:0]  sh_n;
    logic [31:0] sh_wide;
    logic [31:0] prod;
    logic [31:0] quot;
    logic [31:0] rem;
    logic [15:0] divisor;
    logic        div_zero;
    logic [4:0]  norm_n;
    logic [15:0] fmask;
    logic [15:0] fdata;
    logic        bit_res;
    ald_rsp_s    nxt_rsp;

    assign sh_n     = i_req.opb[3:0];
    assign div_zero = (i_req.opb == ALD_WORD_RST);
    // A zero divisor is swapped for one so no X leaks; overflow flags it
    assign divisor  = div_zero ? ALD_STEP_ONE : i_req.opb;

    always_comb begin
        is_sub  = (i_req.op == ALD_SUB) || (i_req.op == ALD_SUBC) || (i_req.op == ALD_CMP)
               || (i_req.op == ALD_CMP_DEC) || (i_req.op == ALD_CMP_INC)
               || (i_req.op == ALD_TWOS);
        add_b   = is_sub ? ~i_req.opb : i_req.opb;
        add_cin = is_sub;
        if (i_req.op == ALD_ADDC) begin
            add_cin = i_req.carry_in; // [RULE1]
        end
        if (i_req.op == ALD_SUBC) begin
            add_cin = ~i_req.carry_in; // [RULE2]
        end
        if (i_req.op == ALD_TWOS) begin
            add_b = ~i_req.opa; // [RULE7]
        end
    end

    assign sum_w = (i_req.op == ALD_TWOS) ? {1'b0, add_b} + 17'h00001
                 : {1'b0, i_req.opa} + {1'b0, add_b} + {16'h0000, add_cin}; // [RULE1] [RULE2]
    assign sum_b = (i_req.op == ALD_TWOS) ? {1'b0, add_b[7:0]} + 9'h001
                 : {1'b0, i_req.opa[7:0]} + {1'b0, add_b[7:0]} + {8'h00, add_cin};

    always_comb begin
        if (i_req.signed_mode) begin
            prod = 32'($signed(i_req.opa) * $signed(i_req.opb)); // [RULE3]
        end else begin
            prod = {16'h0000, i_req.opa} * {16'h0000, i_req.opb}; // [RULE3]
        end
    end

    always_comb begin
        if (i_req.op == ALD_DIVL) begin
            if (i_req.signed_mode) begin
                quot = $signed(i_req.pair) / $signed({{16{divisor[15]}}, divisor}); // [RULE5]
                rem  = $signed(i_req.pair) % $signed({{16{divisor[15]}}, divisor});
            end else begin
                quot = i_req.pair / {16'h0000, divisor}; // [RULE5]
                rem  = i_req.pair % {16'h0000, divisor};
            end
        end else begin
            if (i_req.signed_mode) begin
                quot = 32'($signed(i_req.pair[15:0]) / $signed(divisor)); // [RULE4]
                rem  = 32'($signed(i_req.pair[15:0]) % $signed(divisor));
            end else begin
                quot = {16'h0000, i_req.pair[15:0] / divisor}; // [RULE4]
                rem  = {16'h0000, i_req.pair[15:0] % divisor};
            end
        end
    end

    // Shifts are done on a doubled word so the last bit out lands in bit 16 or 15
    always_comb begin
        unique case (i_req.op)
            ALD_SHL:  sh_wide = {16'h0000, i_req.opa} << sh_n; // [RULE17]
            ALD_ROL:  sh_wide = {i_req.opa, i_req.opa} << sh_n; // [RULE18]
            ALD_ROR:  sh_wide = {i_req.opa, i_req.opa} >> sh_n; // [RULE18]
            ALD_SIGN_FILL_RIGHT_SHIFT: sh_wide = 32'($signed({i_req.opa, 16'h0000}) >>> sh_n); // [RULE19]
            default:  sh_wide = {i_req.opa, 16'h0000} >> sh_n; // [RULE17]
        endcase
    end

    // Normalize count: shifts until the top bit is one
    always_comb begin
        norm_n = 5'h00;
        for (int k = 0; k < ALD_WORD_W; k++) begin
            if (i_req.opa[k]) begin
                norm_n = 5'(ALD_WORD_W - 1 - k); // [RULE16]
            end
        end
    end

    assign fmask = i_req.variant ? {i_req.mask, 8'h00} : {8'h00, i_req.mask};
    assign fdata = i_req.variant ? {i_req.imm, 8'h00} : {8'h00, i_req.imm};

    always_comb begin
        unique case (i_req.op)
            ALD_BIT_COPY: bit_res = i_req.bit_src ^ i_req.variant; // [RULE9]
            ALD_BIT_AND:  bit_res = i_req.bit_dst & i_req.bit_src; // [RULE10]
            ALD_BIT_OR:   bit_res = i_req.bit_dst | i_req.bit_src; // [RULE10]
            ALD_BIT_XOR:  bit_res = i_req.bit_dst ^ i_req.bit_src; // [RULE10]
            default:      bit_res = i_req.bit_dst; // [RULE11]
        endcase
    end

    // ==========================================================
    // Result and flag selection
    always_comb begin
        nxt_rsp            = '0;
        nxt_rsp.valid      = i_req.valid;
        nxt_rsp.write_dst  = 1'b1;
        nxt_rsp.result     = i_req.opa;
        nxt_rsp.result_hi  = ALD_WORD_RST;
        unique case (i_req.op)
            ALD_ADD, ALD_ADDC, ALD_SUB, ALD_SUBC, ALD_TWOS, ALD_CMP,
            ALD_CMP_DEC, ALD_CMP_INC: begin
                nxt_rsp.result = i_req.byte_mode ? {8'h00, sum_b[7:0]} : sum_w[15:0];
                nxt_rsp.flags.c = (i_req.byte_mode ? sum_b[8] : sum_w[16]) ^ is_sub;
                nxt_rsp.flags.v = i_req.byte_mode
                    ? ((i_req.opa[7] == add_b[7]) && (sum_b[7] != i_req.opa[7]))
                    : ((i_req.opa[15] == add_b[15]) && (sum_w[15] != i_req.opa[15]));
                if (i_req.op == ALD_TWOS) begin
                    nxt_rsp.flags.v = i_req.byte_mode ? (i_req.opa[7:0] == 8'h80)
                                                      : (i_req.opa == 16'h8000);
                end
                if (i_req.op == ALD_CMP) begin
                    nxt_rsp.write_dst = 1'b0; // [RULE13]
                end
                if (i_req.op == ALD_CMP_DEC) begin
                    nxt_rsp.result = i_req.opa - (i_req.variant ? ALD_STEP_TWO
                                                                : ALD_STEP_ONE); // [RULE14]
                end
                if (i_req.op == ALD_CMP_INC) begin
                    nxt_rsp.result = i_req.opa + (i_req.variant ? ALD_STEP_TWO
                                                                : ALD_STEP_ONE); // [RULE15]
                end
            end
            ALD_MUL: begin
                nxt_rsp.write_dst  = 1'b0;
                nxt_rsp.write_pair = 1'b1;
                nxt_rsp.result     = prod[15:0];
                nxt_rsp.result_hi  = prod[31:16]; // [RULE3]
            end
            ALD_DIV, ALD_DIVL: begin
                nxt_rsp.write_dst  = 1'b0;
                nxt_rsp.write_pair = 1'b1;
                nxt_rsp.result     = quot[15:0];
                nxt_rsp.result_hi  = rem[15:0];
                nxt_rsp.flags.v    = div_zero
                    || (i_req.signed_mode ? (quot[31:15] != {17{quot[15]}})
                                          : (quot[31:16] != 16'h0000)); // [RULE5]
            end
            ALD_ONES: nxt_rsp.result = ~i_req.opa; // [RULE6]
            ALD_AND:  nxt_rsp.result = i_req.opa & i_req.opb; // [RULE8]
            ALD_OR:   nxt_rsp.result = i_req.opa | i_req.opb; // [RULE8]
            ALD_XOR:  nxt_rsp.result = i_req.opa ^ i_req.opb; // [RULE8]
            ALD_BIT_COPY, ALD_BIT_AND, ALD_BIT_OR, ALD_BIT_XOR, ALD_BIT_CMP: begin
                nxt_rsp.write_dst = (i_req.op != ALD_BIT_CMP); // [RULE11]
                nxt_rsp.result    = {15'h0000, bit_res};
                nxt_rsp.flags.z   = ~(i_req.bit_dst | i_req.bit_src);
                nxt_rsp.flags.n   = i_req.bit_dst ^ i_req.bit_src;
                nxt_rsp.flags.c   = i_req.bit_dst & i_req.bit_src;
                nxt_rsp.flags.v   = i_req.bit_dst | i_req.bit_src;
            end
            ALD_FIELD: begin
                nxt_rsp.result = (i_req.opa & ~fmask) | (fdata & fmask); // [RULE12]
            end
            ALD_NORM: nxt_rsp.result = {11'h000, norm_n}; // [RULE16]
            ALD_SHL, ALD_ROL: begin
                // The rotated word sits in the upper half; the lower half lost the wrap
                nxt_rsp.result  = (i_req.op == ALD_ROL) ? sh_wide[31:16] : sh_wide[15:0];
                nxt_rsp.flags.c = (sh_n != 4'h0) && sh_wide[16];
            end
            ALD_SHR, ALD_ROR, ALD_SIGN_FILL_RIGHT_SHIFT: begin
                nxt_rsp.result  = (i_req.op == ALD_ROR) ? sh_wide[15:0] : sh_wide[31:16];
                // Right rotate: the last bit out becomes the new top bit
                nxt_rsp.flags.c = (i_req.op == ALD_ROR) ? ((sh_n != 4'h0) && sh_wide[15])
                                                        : sh_wide[15];
            end
            default: nxt_rsp.write_dst = 1'b0;
        endcase
        // Byte forms leave the upper byte clear
        if (i_req.byte_mode && (i_req.op inside {ALD_ONES, ALD_AND, ALD_OR, ALD_XOR})) begin
            nxt_rsp.result[15:8] = 8'h00; // [RULE6] [RULE8]
        end
        if (!(i_req.op inside {ALD_BIT_COPY, ALD_BIT_AND, ALD_BIT_OR, ALD_BIT_XOR,
                               ALD_BIT_CMP})) begin
            if (i_req.op == ALD_CMP_DEC || i_req.op == ALD_CMP_INC) begin
                nxt_rsp.flags.z = (sum_w[15:0] == ALD_WORD_RST); // [RULE20]
                nxt_rsp.flags.n = sum_w[15];
            end else if (i_req.byte_mode && !(i_req.op inside {ALD_MUL, ALD_DIV, ALD_DIVL})) begin
                nxt_rsp.flags.z = (nxt_rsp.result[7:0] == 8'h00); // [RULE20]
                nxt_rsp.flags.n = nxt_rsp.result[7];
            end else if (i_req.op == ALD_MUL) begin
                nxt_rsp.flags.z = (prod == 32'h00000000); // [RULE20]
                nxt_rsp.flags.n = prod[31];
            end else begin
                nxt_rsp.flags.z = (nxt_rsp.result == ALD_WORD_RST); // [RULE20]
                nxt_rsp.flags.n = nxt_rsp.result[15];
            end
        end
        if (!i_req.valid) begin
            nxt_rsp = '0;
        end
    end

    // ==========================================================
    // Output register
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_rsp <= '0;
        end else begin
            o_rsp <= nxt_rsp;
        end
    end

    // ==========================================================
    // Checks
    property p_answer;
        @(posedge i_clock) disable iff (i_rst)
        i_req.valid |=> o_rsp.valid;
    endproperty
    a_answer: assert property (p_answer) else $error("No answer after request"); // [RULE20]

    property p_add_word;
        @(posedge i_clock) disable iff (i_rst)
        (i_req.valid && i_req.op == ALD_ADD && !i_req.byte_mode)
        |=> o_rsp.result == 16'($past(i_req.opa) + $past(i_req.opb));
    endproperty
    a_add_word: assert property (p_add_word) else $error("Word add wrong"); // [RULE1]

    property p_sub_borrow;
        @(posedge i_clock) disable iff (i_rst)
        (i_req.valid && i_req.op == ALD_SUB && !i_req.byte_mode)
        |=> o_rsp.flags.c == ($past(i_req.opa) < $past(i_req.opb));
    endproperty
    a_sub_borrow: assert property (p_sub_borrow) else $error("Borrow flag wrong"); // [RULE2]

    property p_ones;
        @(posedge i_clock) disable iff (i_rst)
        (i_req.valid && i_req.op == ALD_ONES)
        |=> o_rsp.result == ($past(i_req.byte_mode) ? {8'h00, ~$past(i_req.opa[7:0])}
                                                    : ~$past(i_req.opa));
    endproperty
    a_ones: assert property (p_ones) else $error("Complement wrong"); // [RULE6]

    property p_twos;
        @(posedge i_clock) disable iff (i_rst)
        (i_req.valid && i_req.op == ALD_TWOS && !i_req.byte_mode)
        |=> 16'(o_rsp.result + $past(i_req.opa)) == ALD_WORD_RST;
    endproperty
    a_twos: assert property (p_twos) else $error("Negate wrong"); // [RULE7]

    property p_cmp_only;
        @(posedge i_clock) disable iff (i_rst)
        (i_req.valid && (i_req.op == ALD_CMP || i_req.op == ALD_BIT_CMP))
        |=> o_rsp.valid && !o_rsp.write_dst && !o_rsp.write_pair;
    endproperty
    a_cmp_only: assert property (p_cmp_only) else $error("Compare wrote result"); // [RULE13]

    property p_cmp_dec;
        @(posedge i_clock) disable iff (i_rst)
        (i_req.valid && i_req.op == ALD_CMP_DEC && i_req.variant)
        |=> 16'(o_rsp.result + 16'h0002) == $past(i_req.opa);
    endproperty
    a_cmp_dec: assert property (p_cmp_dec) else $error("Decrement wrong"); // [RULE14]

    property p_shl_carry;
        @(posedge i_clock) disable iff (i_rst)
        (i_req.valid && i_req.op == ALD_SHL && i_req.opb[3:0] == 4'h1)
        |=> o_rsp.flags.c == $past(i_req.opa[15]) && o_rsp.result[0] == 1'b0;
    endproperty
    a_shl_carry: assert property (p_shl_carry) else $error("Shift carry wrong"); // [RULE17]

    property p_field;
        @(posedge i_clock) disable iff (i_rst)
        (i_req.valid && i_req.op == ALD_FIELD && !i_req.variant)
        |=> o_rsp.result[15:8] == $past(i_req.opa[15:8]);
    endproperty
    a_field: assert property (p_field) else $error("Field touched other byte"); // [RULE12]

endmodule // ald_datapath

`default_nettype wire

// [sim/ald_datapath_tb.sv]
`timescale 1ns/100ps
`default_nettype none

module ald_datapath_tb;
    import ald_pkg::*;

    // ==========================================================
    // Clock, reset and design
    logic     i_clock;
    logic     i_rst;
    ald_req_s req;
    ald_rsp_s o_rsp;
    int       n_mismatch;
    int       checks_done;

    always #25 i_clock = ~i_clock;

    ald_datapath ald_datapath_i (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .i_req   (req),
        .o_rsp   (o_rsp)
    );

    // ==========================================================
    // Shared helpers
    function automatic ald_req_s mk(ald_op_e op, logic [15:0] a, logic [15:0] b,
                                    logic bm = 1'b0, logic vr = 1'b0);
        ald_req_s r;
        r = '0;
        r.valid = 1'b1;
        r.op = op;
        r.opa = a;
        r.opb = b;
        r.byte_mode = bm;
        r.variant = vr;
        return r;
    endfunction

    // Only the fields that the op defines are compared; the rest stay open
    task automatic chk_rsp(input string what, input ald_rsp_s exp, input ald_rsp_s care);
        checks_done++;
        if ((o_rsp & care) !== (exp & care)) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", what, exp & care, o_rsp & care);
        end
    endtask

    // Issue one request, judge the response one cycle later
    task automatic exec(input ald_req_s r, input logic [15:0] res, input logic [15:0] hi,
                        input logic [3:0] fl, input logic [3:0] fc, input logic [1:0] wr);
        ald_rsp_s e;
        ald_rsp_s c;
        logic     bit_op;
        bit_op = r.op inside {ALD_BIT_COPY, ALD_BIT_AND, ALD_BIT_OR, ALD_BIT_XOR};
        e = '0;
        c = '0;
        e.valid = 1'b1;
        e.result = res;
        e.result_hi = hi;
        e.flags = fl;
        {e.write_dst, e.write_pair} = wr;
        c.valid = 1'b1;
        c.write_pair = 1'b1;
        c.write_dst = ~wr[0];
        c.result = (|wr) ? (bit_op ? 16'h0001 : 16'hFFFF) : 16'h0000;
        c.result_hi = wr[0] ? 16'hFFFF : 16'h0000;
        c.flags = fc;
        @(posedge i_clock);
        req <= r;
        @(posedge i_clock);
        req.valid <= 1'b0;
        #1;
        chk_rsp(r.op.name(), e, c);
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_arith;
        ald_req_s r;
        exec(mk(ALD_ADD, 16'h0001, 16'h0002), 16'h0003, 16'h0000, 4'h0, 4'hF, 2'h2);
        exec(mk(ALD_ADD, 16'hFFFF, 16'h0001), 16'h0000, 16'h0000, 4'hA, 4'hF, 2'h2);
        exec(mk(ALD_ADD, 16'h7FFF, 16'h0001), 16'h8000, 16'h0000, 4'h5, 4'hF, 2'h2);
        exec(mk(ALD_ADD, 16'h1280, 16'h3480, 1'b1), 16'h0000, 16'h0000, 4'hB, 4'hF,
             2'h2);
        r = mk(ALD_ADDC, 16'h0001, 16'h0001);
        r.carry_in = 1'b1;
        exec(r, 16'h0003, 16'h0000, 4'h0, 4'hF, 2'h2);
        exec(mk(ALD_SUB, 16'h0005, 16'h0003), 16'h0002, 16'h0000, 4'h0, 4'hF, 2'h2);
        exec(mk(ALD_SUB, 16'h0003, 16'h0005), 16'hFFFE, 16'h0000, 4'h6, 4'hF, 2'h2);
        exec(mk(ALD_SUB, 16'h8000, 16'h0001), 16'h7FFF, 16'h0000, 4'h1, 4'hF, 2'h2);
        r = mk(ALD_SUBC, 16'h0005, 16'h0003);
        r.carry_in = 1'b1;
        exec(r, 16'h0001, 16'h0000, 4'h0, 4'hF, 2'h2);
    endtask

    task automatic t_muldiv;
        ald_req_s r;
        r = mk(ALD_MUL, 16'hFFFF, 16'hFFFF);
        exec(r, 16'h0001, 16'hFFFE, 4'h4, 4'hC, 2'h1);
        r.signed_mode = 1'b1;
        exec(r, 16'h0001, 16'h0000, 4'h0, 4'hC, 2'h1);
        r = mk(ALD_DIV, 16'h0000, 16'h0007);
        r.pair = 32'h0000_0064;
        exec(r, 16'h000E, 16'h0002, 4'h0, 4'h1, 2'h1);
        r.signed_mode = 1'b1;
        r.pair = 32'h0000_FF9C;
        exec(r, 16'hFFF2, 16'hFFFE, 4'h0, 4'h1, 2'h1);
        r = mk(ALD_DIV, 16'h0000, 16'h0000);
        r.pair = 32'h0000_1234;
        exec(r, 16'h1234, 16'h0000, 4'h1, 4'h1, 2'h1);
        r = mk(ALD_DIVL, 16'h0000, 16'h0002);
        r.pair = 32'h0001_0000;
        exec(r, 16'h8000, 16'h0000, 4'h0, 4'h1, 2'h1);
        r = mk(ALD_DIVL, 16'h0000, 16'h0007);
        r.signed_mode = 1'b1;
        r.pair = 32'hFFFF_FF9C;
        exec(r, 16'hFFF2, 16'hFFFE, 4'h0, 4'h1, 2'h1);
    endtask

    task automatic t_logic;
        exec(mk(ALD_AND, 16'hFF0F, 16'h0FF0), 16'h0F00, 16'h0000, 4'h0, 4'hC, 2'h2);
        exec(mk(ALD_OR, 16'h00F0, 16'h0F00), 16'h0FF0, 16'h0000, 4'h0, 4'hC, 2'h2);
        exec(mk(ALD_XOR, 16'hFFFF, 16'hFFFF), 16'h0000, 16'h0000, 4'h8, 4'hC, 2'h2);
        exec(mk(ALD_AND, 16'h12F0, 16'h34F0, 1'b1), 16'h00F0, 16'h0000, 4'h4, 4'hC,
             2'h2);
        exec(mk(ALD_ONES, 16'h00FF, 16'h0000), 16'hFF00, 16'h0000, 4'h4, 4'hC, 2'h2);
        exec(mk(ALD_ONES, 16'h00FF, 16'h0000, 1'b1), 16'h0000, 16'h0000, 4'h8, 4'hC,
             2'h2);
        exec(mk(ALD_TWOS, 16'h0001, 16'h0000), 16'hFFFF, 16'h0000, 4'h4, 4'hC, 2'h2);
        exec(mk(ALD_TWOS, 16'h0001, 16'h0000, 1'b1), 16'h00FF, 16'h0000, 4'h4, 4'hC,
             2'h2);
    endtask

    task automatic t_bits;
        ald_req_s r;
        ald_op_e  ops [6] = '{ALD_BIT_COPY, ALD_BIT_COPY, ALD_BIT_AND, ALD_BIT_OR,
                              ALD_BIT_XOR, ALD_BIT_CMP};
        logic     d;
        logic     s;
        logic     res;
        for (int k = 0; k < 6; k++) begin
            for (int j = 0; j < 4; j++) begin
                {d, s} = j[1:0];
                r = mk(ops[k], 16'h0000, 16'h0000, 1'b0, k == 1);
                r.bit_dst = d;
                r.bit_src = s;
                case (k)
                    0: res = s;
                    1: res = ~s;
                    2: res = d & s;
                    3: res = d | s;
                    default: res = d ^ s;
                endcase
                exec(r, {15'h0000, res}, 16'h0000, {~(d | s), d ^ s, d & s, d | s}, 4'hF,
                     (k == 5) ? 2'h0 : 2'h2);
            end
        end
    endtask

    task automatic t_field_cmp;
        ald_req_s r;
        r = mk(ALD_FIELD, 16'hA55A, 16'h0000, 1'b0, 1'b1);
        r.mask = 8'hF0;
        r.imm = 8'h3C;
        exec(r, 16'h355A, 16'h0000, 4'h0, 4'h0, 2'h2);
        r.variant = 1'b0;
        exec(r, 16'hA53A, 16'h0000, 4'h0, 4'h0, 2'h2);
        exec(mk(ALD_CMP, 16'h0005, 16'h0005), 16'h0000, 16'h0000, 4'h8, 4'hF, 2'h0);
        exec(mk(ALD_CMP, 16'h0003, 16'h0005), 16'h0000, 16'h0000, 4'h6, 4'hF, 2'h0);
        exec(mk(ALD_CMP, 16'h0180, 16'h0280, 1'b1), 16'h0000, 16'h0000, 4'h8, 4'hF,
             2'h0);
        exec(mk(ALD_CMP_DEC, 16'h0005, 16'h0005), 16'h0004, 16'h0000, 4'h8, 4'hF,
             2'h2);
        exec(mk(ALD_CMP_DEC, 16'h0005, 16'h0005, 1'b0, 1'b1), 16'h0003, 16'h0000, 4'h8, 4'hF,
             2'h2);
        exec(mk(ALD_CMP_INC, 16'hFFFF, 16'h0000), 16'h0000, 16'h0000, 4'h4, 4'hF,
             2'h2);
        exec(mk(ALD_CMP_INC, 16'hFFFF, 16'h0000, 1'b0, 1'b1), 16'h0001, 16'h0000, 4'h4, 4'hF,
             2'h2);
    endtask

    task automatic t_norm_shift;
        exec(mk(ALD_NORM, 16'h0001, 16'h0000), 16'h000F, 16'h0000, 4'h0, 4'h0, 2'h2);
        exec(mk(ALD_NORM, 16'h0000, 16'h0000), 16'h0000, 16'h0000, 4'h0, 4'h0, 2'h2);
        exec(mk(ALD_NORM, 16'h8000, 16'h0000), 16'h0000, 16'h0000, 4'h0, 4'h0, 2'h2);
        exec(mk(ALD_NORM, 16'h00F0, 16'h0000), 16'h0008, 16'h0000, 4'h0, 4'h0, 2'h2);
        exec(mk(ALD_SHL, 16'h8001, 16'h0001), 16'h0002, 16'h0000, 4'h2, 4'hE, 2'h2);
        exec(mk(ALD_SHL, 16'h8001, 16'h0000), 16'h8001, 16'h0000, 4'h4, 4'hE, 2'h2);
        exec(mk(ALD_SHL, 16'h0003, 16'h000F), 16'h8000, 16'h0000, 4'h6, 4'hE, 2'h2);
        exec(mk(ALD_SHR, 16'h8001, 16'h0001), 16'h4000, 16'h0000, 4'h2, 4'hE, 2'h2);
        exec(mk(ALD_SHR, 16'h0001, 16'h0001), 16'h0000, 16'h0000, 4'hA, 4'hE, 2'h2);
        exec(mk(ALD_ROL, 16'h8001, 16'h0001), 16'h0003, 16'h0000, 4'h2, 4'hE, 2'h2);
        exec(mk(ALD_ROR, 16'h8001, 16'h0001), 16'hC000, 16'h0000, 4'h6, 4'hE, 2'h2);
        exec(mk(ALD_SIGN_FILL_RIGHT_SHIFT, 16'h8000, 16'h000F), 16'hFFFF, 16'h0000, 4'h4, 4'hE, 2'h2);
    endtask

    // Back to back, idle, unused code and a reset with a response in flight
    task automatic t_misc;
        ald_rsp_s e;
        ald_rsp_s c;
        c = '0;
        c.valid = 1'b1;
        c.result = 16'hFFFF;
        e = c;
        @(posedge i_clock);
        req <= mk(ALD_ADD, 16'h0001, 16'h0002);
        @(posedge i_clock);
        req <= mk(ALD_SUB, 16'h0009, 16'h0004);
        #1;
        e.result = 16'h0003;
        chk_rsp("back1", e, c);
        @(posedge i_clock);
        req.valid <= 1'b0;
        #1;
        e.result = 16'h0005;
        chk_rsp("back2", e, c);
        @(posedge i_clock);
        #1;
        chk_rsp("idle", '0, c);
        exec(mk(ald_op_e'(5'h1F), 16'h1111, 16'h2222), 16'h0000, 16'h0000, 4'h0, 4'h0,
             2'h0);
        @(posedge i_clock);
        req <= mk(ALD_ADD, 16'h0004, 16'h0004);
        @(posedge i_clock);
        req.valid <= 1'b0;
        i_rst <= 1'b1;
        #1;
        chk_rsp("reset", '0, '1);
        @(posedge i_clock);
        i_rst <= 1'b0;
        @(posedge i_clock);
        #1;
        chk_rsp("after_reset", '0, '1);
    endtask

    // ==========================================================
    // Run control
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        i_clock = 1'b0;
        i_rst = 1'b1;
        req = '0;
        n_mismatch = 0;
        checks_done = 0;
        repeat (8) @(posedge i_clock);
        i_rst <= 1'b0;
        #1;
        chk_rsp("reset_value", '0, '1);
        t_arith();
        t_muldiv();
        t_logic();
        t_bits();
        t_field_cmp();
        t_norm_shift();
        t_misc();
        summarize();
    end

    // About 160 cycles of traffic; the margin covers a stuck handshake only
    initial begin
        repeat (5000) @(posedge i_clock);
        n_mismatch++;
        summarize();
    end
endmodule // ald_datapath_tb

`default_nettype wire
